// >>> src/uf9b_serial_port.sv
// nine-bit variable-rate serial port with narrow and wide baud timers
`timescale 1ns/1ps
module uf9b_serial_port (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,       // register address
  input wire logic sfr_wr,               // write strobe
  input wire logic sfr_rd,               // read strobe
  input wire logic [7:0] sfr_wdata,      // write data
  output logic [7:0] sfr_rdata_r,        // read data, valid cycle after strobe
  input wire logic rate_doubler_bit,
  input wire logic eight_bit_timer_clock_select,
  input wire logic [7:0] eight_bit_timer_reload,
  input wire logic [7:0] wide_timer_reload_high,
  input wire logic [7:0] wide_timer_reload_low,
  input wire logic [7:0] slave_address_register,
  input wire logic [7:0] slave_address_mask,
  input wire logic multiproc_enable,     // accept only addressed frames
  input wire logic receive_enable,       // receiver on
  input wire logic tx_ninth_bit,         // programmable ninth bit to send
  input wire logic wide_timer_ext_pin,   // external capture/reload input
  input wire logic rx_pin,               // serial input
  output logic tx_pin_r,                 // serial output
  output logic tx_busy_r,                // frame in progress
  output logic tx_done_r,                // one-cycle pulse at stop bit start
  output logic rx_full_r,                // received byte waiting
  output logic rx_ninth_bit_r,           // ninth bit of last accepted frame
  output logic [15:0] wide_timer_capture_r
);
  import uf9b_pkg::*;

  logic [7:0] control_r;                 // timer_four_control
  logic [7:0] rx_latch_r;                // receive side of serial_data_buffer
  logic [3:0] slow_pre_r;                // divide-by-12 prescaler
  logic half_pre_r;                      // divide-by-2 prescaler
  logic [7:0] narrow_cnt_r;              // eight-bit auto-reload timer
  logic narrow_ovf_r;                    // narrow rollover pulse
  logic [15:0] wide_cnt_r;               // sixteen-bit timer
  logic wide_ovf_r;                      // wide rollover pulse
  logic ext_prev_r;                      // previous level of external pin
  logic [1:0] half_sel_r;                // per-direction overflow halver
  logic [1:0] tick_r;                    // per-direction 16x bit tick
  logic [10:0] tx_shift_r;               // outgoing frame
  logic [3:0] tx_bit_r;                  // bit index in frame
  logic [3:0] tx_ovs_r;                  // ticks within bit
  uf9b_rx_state_t rx_state_r;
  logic [3:0] rx_bit_r;
  logic [3:0] rx_ovs_r;
  logic [8:0] rx_shift_r;                // data plus ninth bit
  logic baud_mode;                       // wide timer forced to baud generator
  logic narrow_en;
  logic wide_en;
  logic ext_fall;
  logic wr_ctrl;
  logic wr_buf;
  logic rd_buf;
  logic [15:0] wide_reload;
  logic rx_accept;

  assign baud_mode = control_r[BIT_RX_CLK_SEL] | control_r[BIT_TX_CLK_SEL];
  assign narrow_en = eight_bit_timer_clock_select | (slow_pre_r == SLOW_PRESCALE_LAST);
  assign wide_en = control_r[BIT_RUN] & (baud_mode ? half_pre_r
                                                   : (slow_pre_r == SLOW_PRESCALE_LAST));
  assign wide_reload = {wide_timer_reload_high, wide_timer_reload_low};
  assign ext_fall = ext_prev_r & ~wide_timer_ext_pin & control_r[BIT_EXT_ENABLE] & ~baud_mode;
  assign wr_ctrl = sfr_wr & (sfr_addr == SFR_TIMER_FOUR_CONTROL);
  assign wr_buf = sfr_wr & (sfr_addr == SFR_SERIAL_DATA_BUFFER);
  assign rd_buf = sfr_rd & (sfr_addr == SFR_SERIAL_DATA_BUFFER);

  // prescalers: system_clock/12 and system_clock/2
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      slow_pre_r <= 4'h0;
      half_pre_r <= 1'b0;
    end else begin
      slow_pre_r <= (slow_pre_r == SLOW_PRESCALE_LAST) ? 4'h0 : slow_pre_r + 4'h1;
      half_pre_r <= ~half_pre_r;
    end
  end

  // narrow auto-reload timer
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      narrow_cnt_r <= 8'h00;
      narrow_ovf_r <= 1'b0;
    end else begin
      narrow_ovf_r <= 1'b0;
      if (narrow_en) begin
        if (narrow_cnt_r == NARROW_TOP) begin
          narrow_cnt_r <= eight_bit_timer_reload;
          narrow_ovf_r <= 1'b1;
        end else begin
          narrow_cnt_r <= narrow_cnt_r + 8'h01;
        end
      end
    end
  end

  // wide timer: baud generator, auto-reload or capture
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wide_cnt_r <= 16'h0000;
      wide_ovf_r <= 1'b0;
      ext_prev_r <= 1'b1;
      wide_timer_capture_r <= 16'h0000;
    end else begin
      wide_ovf_r <= 1'b0;
      ext_prev_r <= wide_timer_ext_pin;
      if (ext_fall && control_r[BIT_CAPTURE]) begin
        wide_timer_capture_r <= wide_cnt_r;  // capture on falling edge
      end
      if (ext_fall && !control_r[BIT_CAPTURE]) begin
        wide_cnt_r <= wide_reload;           // external reload
      end else if (wide_en) begin
        if (wide_cnt_r == WIDE_TOP) begin
          // baud mode always reloads; capture mode just wraps
          wide_cnt_r <= (baud_mode || !control_r[BIT_CAPTURE]) ? wide_reload : 16'h0000;
          wide_ovf_r <= 1'b1;
        end else begin
          wide_cnt_r <= wide_cnt_r + 16'h0001;
        end
      end
    end
  end

  // control register with sticky hardware flags; set beats clear
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      control_r <= TIMER_FOUR_CONTROL_RST;
    end else begin
      if (wr_ctrl) begin
        control_r <= sfr_wdata;
      end
      if (wide_ovf_r && !baud_mode) begin
        control_r[BIT_OVERFLOW] <= 1'b1;
      end
      if (ext_fall) begin
        control_r[BIT_EXTERNAL] <= 1'b1;
      end
    end
  end

  // per-direction 16x tick from selected timer
  for (genvar d = 0; d < 2; d++) begin : g_dir
    logic use_wide;
    logic src_ovf;
    assign use_wide = control_r[d == 0 ? BIT_TX_CLK_SEL : BIT_RX_CLK_SEL];
    assign src_ovf = use_wide ? wide_ovf_r : narrow_ovf_r;
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        half_sel_r[d] <= 1'b0;
        tick_r[d] <= 1'b0;
      end else begin
        tick_r[d] <= 1'b0;
        if (src_ovf) begin
          if (use_wide || rate_doubler_bit) begin
            tick_r[d] <= 1'b1;               // 16 overflows per bit
          end else begin
            half_sel_r[d] <= ~half_sel_r[d];
            tick_r[d] <= half_sel_r[d];      // 32 overflows per bit
          end
        end
      end
    end
  end

  // transmitter
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_shift_r <= 11'h7ff;
      tx_bit_r <= 4'h0;
      tx_ovs_r <= 4'h0;
      tx_busy_r <= 1'b0;
      tx_pin_r <= 1'b1;
      tx_done_r <= 1'b0;
    end else begin
      tx_done_r <= 1'b0;
      if (!tx_busy_r) begin
        tx_pin_r <= 1'b1;
        if (wr_buf) begin
          // stop, ninth, data lsb first, start
          tx_shift_r <= {1'b1, tx_ninth_bit, sfr_wdata, 1'b0};
          tx_busy_r <= 1'b1;
          tx_bit_r <= 4'h0;
          tx_ovs_r <= 4'h0;
        end
      end else if (tick_r[0]) begin
        tx_pin_r <= tx_shift_r[0];
        tx_ovs_r <= tx_ovs_r + 4'h1;
        if (tx_bit_r == TX_FRAME_LAST && tx_ovs_r == 4'h0) begin
          tx_done_r <= 1'b1;                 // stop bit now on the line
        end
        if (tx_ovs_r == OVS_LAST) begin
          tx_shift_r <= {1'b1, tx_shift_r[10:1]};
          tx_bit_r <= tx_bit_r + 4'h1;
          if (tx_bit_r == TX_FRAME_LAST) begin
            tx_busy_r <= 1'b0;               // frame of 11 bits sent
            tx_pin_r <= 1'b1;
          end
        end
      end
    end
  end

  // frame accepted: latch free, stop high, address check when enabled
  assign rx_accept = !rx_full_r && rx_pin &&
                     (!multiproc_enable ||
                      (rx_shift_r[8] &&
                       ((rx_shift_r[7:0] & slave_address_mask) ==
                        (slave_address_register & slave_address_mask))));

  // receiver
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_state_r <= UF9B_RX_IDLE;
      rx_bit_r <= 4'h0;
      rx_ovs_r <= 4'h0;
      rx_shift_r <= 9'h000;
      rx_latch_r <= SERIAL_DATA_BUFFER_RST;
      rx_ninth_bit_r <= 1'b0;
      rx_full_r <= 1'b0;
    end else begin
      if (rd_buf) begin
        rx_full_r <= 1'b0;                   // read empties the latch
      end
      case (rx_state_r)
        UF9B_RX_IDLE: begin
          if (tick_r[1] && receive_enable && !rx_pin) begin
            rx_state_r <= UF9B_RX_START;
            rx_ovs_r <= 4'h0;
          end
        end
        UF9B_RX_START: begin
          if (tick_r[1]) begin
            rx_ovs_r <= rx_ovs_r + 4'h1;
            if (rx_ovs_r == OVS_MID - 4'h1) begin
              // false start if line went high again
              rx_state_r <= rx_pin ? UF9B_RX_IDLE : UF9B_RX_BITS;
              rx_ovs_r <= 4'h0;
              rx_bit_r <= 4'h0;
            end
          end
        end
        UF9B_RX_BITS: begin
          if (tick_r[1]) begin
            rx_ovs_r <= rx_ovs_r + 4'h1;
            if (rx_ovs_r == OVS_LAST) begin
              rx_bit_r <= rx_bit_r + 4'h1;
              if (rx_bit_r == RX_STOP_INDEX) begin
                rx_state_r <= UF9B_RX_IDLE;
                if (rx_accept) begin
                  rx_latch_r <= rx_shift_r[7:0];
                  rx_ninth_bit_r <= rx_shift_r[8];
                  rx_full_r <= 1'b1;               // set beats read clear
                end
              end else begin
                rx_shift_r <= {rx_pin, rx_shift_r[8:1]};  // lsb first
              end
            end
          end
        end
        default: rx_state_r <= UF9B_RX_IDLE;
      endcase
    end
  end

  // register read port
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sfr_rdata_r <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        SFR_TIMER_FOUR_CONTROL: sfr_rdata_r <= control_r;
        SFR_SERIAL_DATA_BUFFER: sfr_rdata_r <= rx_latch_r;
        default: sfr_rdata_r <= 8'h00;
      endcase
    end
  end
endmodule : uf9b_serial_port

// >>> src/uf9b_pkg.sv
// constants for the nine-bit variable-rate serial port and its baud timers
package uf9b_pkg;
  // register addresses in the special function register space
  localparam logic [7:0] SFR_TIMER_FOUR_CONTROL = 8'hc9;
  localparam logic [7:0] SFR_SERIAL_DATA_BUFFER = 8'hf2;
  // reset values
  localparam logic [7:0] TIMER_FOUR_CONTROL_RST = 8'h00;
  localparam logic [7:0] SERIAL_DATA_BUFFER_RST = 8'h00;
  // timer_four_control field positions
  localparam int BIT_OVERFLOW = 7;
  localparam int BIT_EXTERNAL = 6;
  localparam int BIT_RX_CLK_SEL = 5;
  localparam int BIT_TX_CLK_SEL = 4;
  localparam int BIT_EXT_ENABLE = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_COUNTER = 1;
  localparam int BIT_CAPTURE = 0;
  // timing constants
  localparam logic [3:0] SLOW_PRESCALE_LAST = 4'hb;  // system_clock / 12
  localparam logic [3:0] OVS_LAST = 4'hf;            // 16 ticks per bit
  localparam logic [3:0] OVS_MID = 4'h7;             // mid-bit sample point
  localparam logic [3:0] TX_FRAME_LAST = 4'ha;       // 11 bits per frame
  localparam logic [3:0] RX_STOP_INDEX = 4'h9;       // 8 data, ninth, stop
  localparam logic [7:0] NARROW_TOP = 8'hff;
  localparam logic [15:0] WIDE_TOP = 16'hffff;
  // receiver states
  typedef enum logic [1:0] {UF9B_RX_IDLE, UF9B_RX_START, UF9B_RX_BITS} uf9b_rx_state_t;
endpackage : uf9b_pkg

// >>> dv/uf9b_serial_port_properties.sv
// boundary checks for the nine-bit serial port
`timescale 1ns/1ps
module uf9b_properties
  import uf9b_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata_r,
  input wire logic tx_pin_r,
  input wire logic tx_busy_r,
  input wire logic tx_done_r,
  input wire logic rx_full_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic ctl_rd_r;  // control read data valid now
  logic [2:0] wsel_r;  // last written overflow bit and select bits
  // shadow of control accesses
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctl_rd_r <= 1'b0;
      wsel_r <= 3'h0;
    end else begin
      ctl_rd_r <= sfr_rd && sfr_addr == SFR_TIMER_FOUR_CONTROL;
      if (sfr_wr && sfr_addr == SFR_TIMER_FOUR_CONTROL) begin
        wsel_r <= {sfr_wdata[7], sfr_wdata[5:4]};
      end
    end
  end
  // buffer write accepted while idle
  sequence s_idle_wr;
    sfr_wr && sfr_addr == SFR_SERIAL_DATA_BUFFER && !tx_busy_r;
  endsequence
  chk_idle_high: assert property (!tx_busy_r |-> tx_pin_r)
    else $error("line low while idle");
  chk_stop_high: assert property (tx_done_r |-> tx_pin_r && tx_busy_r)
    else $error("stop bit not high");
  chk_done_pulse: assert property (tx_done_r |=> !tx_done_r)
    else $error("done pulse too long");
  chk_write_starts: assert property (s_idle_wr |=> tx_busy_r)
    else $error("write did not start frame");
  chk_busy_hold: assert property ($rose(tx_busy_r) |-> tx_busy_r[*8])
    else $error("frame ended early");
  chk_unmapped_zero: assert property (sfr_rd && sfr_addr != SFR_TIMER_FOUR_CONTROL
    && sfr_addr != SFR_SERIAL_DATA_BUFFER |=> sfr_rdata_r == 8'h00)
    else $error("unmapped read not zero");
  chk_full_sticky: assert property (rx_full_r && !(sfr_rd
    && sfr_addr == SFR_SERIAL_DATA_BUFFER) |=> rx_full_r)
    else $error("receive flag lost");
  chk_baud_no_flag: assert property (ctl_rd_r && wsel_r[1:0] != 2'b00
    && !wsel_r[2] |-> !sfr_rdata_r[7])
    else $error("overflow flag in baud mode");
endmodule : uf9b_properties

// >>> dv/uf9b_remote_link.sv
// remote serial device facing the tx and rx lines
`timescale 1ns/1ps
module uf9b_remote_link (
  input wire logic clk_sys,
  input wire logic tx_line,  // device output
  output logic rx_line  // device input, idle high
);
  initial rx_line = 1'b1;
  // one edge, then settle past it
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick
  // start, data lsb first, ninth, stop
  task automatic send(input int bit_cyc, input logic [8:0] frame);
    logic [10:0] bits;
    bits = {1'b1, frame, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_line = bits[i];
      repeat (bit_cyc) tick();
    end
  endtask : send
  // capture a frame; span counts start fall to first high
  task automatic take(input int bit_cyc, output logic [8:0] frame, output int span);
    span = 0;
    do tick(); while (tx_line !== 1'b0);
    for (int c = 1; c <= 10 * bit_cyc; c++) begin
      tick();
      if (span == 0 && tx_line === 1'b1) span = c;
      if (c > bit_cyc && c % bit_cyc == bit_cyc / 2) frame[c / bit_cyc - 1] = tx_line;
    end
  endtask : take
endmodule : uf9b_remote_link

// >>> dv/uf9b_serial_port_test.sv
// self-checking bench for the nine-bit serial port
`timescale 1ns/1ps
module uf9b_serial_port_test;
  import uf9b_pkg::*;
  typedef struct {logic [7:0] ctl; logic dbl; logic t1m; logic [7:0] r8; logic [15:0] r16;
    logic [8:0] frame;} uf9b_row_t;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, r8 = 8'h00, r16h = 8'h00, r16l = 8'h00;
  logic [7:0] saddr = 8'h00, smask = 8'h00, sfr_rdata_r, rd_val;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, dbl = 1'b0, t1m = 1'b0, mp_en = 1'b0, ext_pin = 1'b1;
  logic tx_ninth = 1'b0, tx_pin_r, tx_busy_r, tx_done_r, rx_full_r, rx_ninth_bit_r;
  logic [8:0] got;
  logic [15:0] cap;  // captured wide count
  wire rx_pin;
  int span, tb_bit, rb_bit, fail_count = 0, comparisons = 0;
  // control, doubler, narrow clock, reloads, frame
  uf9b_row_t rows [5] = '{'{8'h00, 1'b1, 1'b1, 8'hff, 16'h0000, 9'h080},
    '{8'h00, 1'b0, 1'b1, 8'hfe, 16'h0000, 9'h100}, '{8'h14, 1'b1, 1'b0, 8'hff, 16'hffff, 9'h001},
    '{8'h34, 1'b0, 1'b0, 8'h00, 16'hffff, 9'h05a}, '{8'h24, 1'b1, 1'b1, 8'hff, 16'hfffe, 9'h140}};
  always #2.5 clk_sys = ~clk_sys;
  uf9b_serial_port DUT (.clk_sys(clk_sys), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r), .rate_doubler_bit(dbl),
    .eight_bit_timer_clock_select(t1m), .eight_bit_timer_reload(r8),
    .wide_timer_reload_high(r16h), .wide_timer_reload_low(r16l), .slave_address_register(saddr),
    .slave_address_mask(smask), .multiproc_enable(mp_en), .receive_enable(1'b1),
    .tx_ninth_bit(tx_ninth), .wide_timer_ext_pin(ext_pin), .rx_pin(rx_pin), .tx_pin_r(tx_pin_r),
    .tx_busy_r(tx_busy_r), .tx_done_r(tx_done_r), .rx_full_r(rx_full_r),
    .rx_ninth_bit_r(rx_ninth_bit_r), .wide_timer_capture_r(cap));
  uf9b_remote_link link (.clk_sys(clk_sys), .tx_line(tx_pin_r), .rx_line(rx_pin));
  // cycles per bit from timer settings
  function automatic int bit_cycles(uf9b_row_t r, logic wide);
    if (wide)
      return 32 * (65536 - int'(r.r16));
    return 32 * (256 - int'(r.r8)) * (r.t1m ? 1 : 12) / (r.dbl ? 2 : 1);
  endfunction : bit_cycles
  // bit times from start fall to first high
  function automatic int first_one(logic [8:0] f);
    for (int k = 0; k < 9; k++) if (f[k]) return k + 1;
    return 10;
  endfunction : first_one
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    link.tick();
    sfr_wr = 1'b0;
    link.tick();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_rd = 1'b1;
    link.tick();
    sfr_rd = 1'b0;
    d = sfr_rdata_r;
    link.tick();
  endtask : rd
  task automatic wait_idle();
    for (int n = 0; n < 10000 && tx_busy_r !== 1'b0; n++) link.tick();
    check("tx idle", 0, tx_busy_r);
  endtask : wait_idle
  task automatic end_of_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  // watchdog, far beyond the roughly 7k cycles of the run
  initial begin
    #300000;
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    #1 reset = 1'b0;
    // park the wide timer at its reload; from zero a baud row would wait a full count
    {r16h, r16l} = 16'hffff;
    wr(SFR_TIMER_FOUR_CONTROL, 8'h08);
    ext_pin = 1'b0;
    link.tick();
    ext_pin = 1'b1;
    foreach (rows[i]) begin
      {dbl, t1m, r8, tx_ninth} = {rows[i].dbl, rows[i].t1m, rows[i].r8, rows[i].frame[8]};
      {r16h, r16l} = rows[i].r16;
      tb_bit = bit_cycles(rows[i], rows[i].ctl[BIT_TX_CLK_SEL]);
      rb_bit = bit_cycles(rows[i], rows[i].ctl[BIT_RX_CLK_SEL]);
      wr(SFR_TIMER_FOUR_CONTROL, rows[i].ctl);
      fork
        wr(SFR_SERIAL_DATA_BUFFER, rows[i].frame[7:0]);
        link.take(tb_bit, got, span);
      join
      check("tx frame", rows[i].frame, got);
      check("tx span", first_one(rows[i].frame) * tb_bit, span);
      wait_idle();
      link.send(rb_bit, rows[i].frame);
      check("rx full", 1, rx_full_r);
      check("rx ninth", rows[i].frame[8], rx_ninth_bit_r);
      rd(SFR_SERIAL_DATA_BUFFER, rd_val);
      check("rx data", rows[i].frame[7:0], rd_val);
      $display("row %0d done", i);
    end
    reset = 1'b1;
    link.tick();
    reset = 1'b0;
    check("tx line", 1, tx_pin_r);
    rd(SFR_TIMER_FOUR_CONTROL, rd_val);
    check("ctl reset", TIMER_FOUR_CONTROL_RST, rd_val);
    rd(SFR_SERIAL_DATA_BUFFER, rd_val);
    check("buf reset", SERIAL_DATA_BUFFER_RST, rd_val);
    rd(8'h00, rd_val);
    check("unmapped", 8'h00, rd_val);
    fork
      begin
        wr(SFR_SERIAL_DATA_BUFFER, 8'h80);
        wr(SFR_SERIAL_DATA_BUFFER, 8'h01);
      end
      link.take(16, got, span);
    join
    check("busy write", {tx_ninth, 8'h80}, got);
    wait_idle();
    $display("reset and busy test done");
    wr(SFR_TIMER_FOUR_CONTROL, 8'h08);
    ext_pin = 1'b0;
    repeat (4) link.tick();
    rd(SFR_TIMER_FOUR_CONTROL, rd_val);
    check("ext flag", 8'h48, rd_val);
    ext_pin = 1'b1;
    repeat (20) link.tick();
    rd(SFR_TIMER_FOUR_CONTROL, rd_val);
    check("ext sticky", 8'h48, rd_val);
    {r16h, r16l} = 16'hffff;
    wr(SFR_TIMER_FOUR_CONTROL, 8'h04);
    repeat (40) link.tick();
    rd(SFR_TIMER_FOUR_CONTROL, rd_val);
    check("ovf flag", 8'h84, rd_val);
    wr(SFR_TIMER_FOUR_CONTROL, 8'h00);
    repeat (4) link.tick();
    wr(SFR_TIMER_FOUR_CONTROL, 8'h14);
    repeat (40) link.tick();
    rd(SFR_TIMER_FOUR_CONTROL, rd_val);
    check("baud no flag", 8'h14, rd_val);
    wr(SFR_TIMER_FOUR_CONTROL, 8'h00);
    // stopped counter sits at its reload; a falling edge captures it
    wr(SFR_TIMER_FOUR_CONTROL, 8'h09);
    ext_pin = 1'b0;
    repeat (4) link.tick();
    ext_pin = 1'b1;
    check("capture", 16'hffff, cap);
    wr(SFR_TIMER_FOUR_CONTROL, 8'h00);
    $display("flag test done");
    {mp_en, saddr, smask} = {1'b1, 8'h5a, 8'hf0};
    link.send(16, 9'h133);
    link.send(16, 9'h05a);
    check("addr miss", 0, rx_full_r);
    link.send(16, 9'h15f);
    link.send(16, 9'h155);
    check("addr hit", 1, rx_full_r);
    rd(SFR_SERIAL_DATA_BUFFER, rd_val);
    check("full keeps", 8'h5f, rd_val);
    $display("address test done");
    end_of_test();
  end
endmodule : uf9b_serial_port_test
bind uf9b_serial_port uf9b_properties chk (.clk_sys(clk_sys), .reset(reset), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r),
  .tx_pin_r(tx_pin_r), .tx_busy_r(tx_busy_r), .tx_done_r(tx_done_r), .rx_full_r(rx_full_r));
